// >>> core/acp16_pkg.sv
// Package of constants for the counter array 16-bit PWM block
package acp16_pkg;

	// ----------------------------------------------------------------
	// Timebase select encodings
	// ----------------------------------------------------------------
	localparam logic [2:0] ACP16_TB_DIV12 = 3'h0;
	localparam logic [2:0] ACP16_TB_DIV4 = 3'h1;
	localparam logic [2:0] ACP16_TB_TIMER0 = 3'h2;
	localparam logic [2:0] ACP16_TB_EXT_EDGE = 3'h3;
	localparam logic [2:0] ACP16_TB_SYSTEM_CLOCK = 3'h4;
	localparam logic [2:0] ACP16_TB_XOSC8 = 3'h5;

	// ----------------------------------------------------------------
	// Divider counts and reset values
	// ----------------------------------------------------------------
	localparam int ACP16_DIV12_COUNT = 12;
	localparam int ACP16_DIV4_COUNT = 4;
	localparam int ACP16_XOSC_DIV = 8;
	localparam logic [15:0] ACP16_COUNT_RESET = 16'h0000;
	localparam logic [15:0] ACP16_COUNT_MAX = 16'hFFFF;
	localparam logic [15:0] ACP16_COMPARE_RESET = 16'h0000;
	localparam logic [7:0] ACP16_SNAP_RESET = 8'h00;

endpackage : acp16_pkg

// >>> core/acp16_sync.sv
// Three-stage synchroniser with agreement-based change detection
`timescale 1ns/1ps
module acp16_sync
	import acp16_pkg::*;
(
	input wire logic clk, // System clock
	input wire logic rst, // Async reset, active high
	input wire logic async_in, // Pin or foreign-domain level
	output logic level_out, // Filtered level
	output logic fall_pulse // One-cycle pulse on a high-to-low change
);

	logic s1_reg;
	logic s2_reg;
	logic s3_reg;

	// Shift chain; first stage feeds only the second
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
		end else begin
			s1_reg <= async_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	// Level updates only once stages two and three agree
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			level_out <= 1'b0;
		end else if (s2_reg == s3_reg) begin
			level_out <= s3_reg;
		end
	end

	// Falling change seen when agreed level drops
	assign fall_pulse = level_out & ~s2_reg & ~s3_reg;

endmodule : acp16_sync

// >>> core/acp16_pwm.sv
// 16-bit PWM output stage of one capture/compare module
`timescale 1ns/1ps
module acp16_pwm
	import acp16_pkg::*;
(
	input wire logic clk, // System clock
	input wire logic rst, // Async reset, active high
	input wire logic active, // Module in 16-bit PWM mode
	input wire logic tick, // Counter advance this cycle
	input wire logic [15:0] count, // Live counter value
	input wire logic [15:0] compare, // Full compare value
	output logic pwm_out, // Output level
	output logic match_pulse // Comparator match event
);

	logic [15:0] count_next;

	assign count_next = count + 16'h0001;

	// Match on the value the counter is about to take
	assign match_pulse = active & tick & (count_next == compare);

	// High on match, low on wrap; held low while disabled
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pwm_out <= 1'b0;
		end else if (!active) begin
			pwm_out <= 1'b0;
		end else if (match_pulse) begin
			pwm_out <= 1'b1;
		end else if (tick && count == ACP16_COUNT_MAX) begin
			pwm_out <= 1'b0;
		end
	end

endmodule : acp16_pwm

// >>> core/acp16_top.sv
// Counter array with 16-bit counter, snapshot read and one 16-bit PWM module
`timescale 1ns/1ps
module acp16_top
	import acp16_pkg::*;
(
	input wire logic clk, // System clock, 25 MHz
	input wire logic rst, // Async reset, active high
	input wire logic cpu_idle, // Processor in idle mode
	input wire logic timer0_overflow, // One-cycle pulse from timer zero
	input wire logic external_count_input, // Edge input pin
	input wire logic ext_osc_div8, // External oscillator divided by eight
	input wire logic [2:0] timebase_select, // Count source
	input wire logic idle_suspend, // Halt counting in idle
	input wire logic overflow_irq_enable, // Overflow interrupt enable
	input wire logic overflow_flag_clear, // Software clears overflow flag
	input wire logic count_wr_low, // Write strobe, count low byte
	input wire logic count_wr_high, // Write strobe, count high byte
	input wire logic count_rd_low, // Read strobe, count low byte
	input wire logic count_rd_high, // Read strobe, count high byte
	input wire logic [7:0] wr_data, // Write data byte
	input wire logic pwm_enable, // Module PWM enable
	input wire logic pwm_wide_select, // Module 16-bit PWM select
	input wire logic match_flag_enable, // Module match flag enable
	input wire logic module_irq_enable, // Module interrupt enable
	input wire logic comparator_enable_wr, // Direct write of comparator enable
	input wire logic comparator_enable_val, // Value for direct write
	input wire logic compare_wr_low, // Write strobe, compare low byte
	input wire logic compare_wr_high, // Write strobe, compare high byte
	input wire logic match_flag_clear, // Software clears module flag
	output logic [7:0] rd_data, // Read data for count reads
	output logic counter_overflow_flag, // Sticky overflow flag
	output logic module_match_flag, // Sticky module match flag
	output logic comparator_enable, // Comparator enable state
	output logic [15:0] compare_value, // Current compare value
	output logic [15:0] count_value, // Live counter
	output logic overflow_irq, // Overflow interrupt request
	output logic module_irq, // Module interrupt request
	output logic module_output_pin // PWM output pin
);

	// ----------------------------------------------------------------
	// Timebase generation
	// ----------------------------------------------------------------
	logic [3:0] div12_reg;
	logic [1:0] div4_reg;
	logic ext_fall;
	logic xosc_level;
	logic xosc_prev_reg;
	logic xosc_rise;
	logic src_tick;
	logic tick;
	logic [15:0] count_reg;
	logic [7:0] snap_reg;
	logic [15:0] compare_reg;
	logic cmp_en_reg;
	logic pwm_active;
	logic match_pulse;
	logic wrap;
	logic count_step;

	// Wrap-around counter used for both prescalers
	function automatic logic [3:0] acp16_wrap_inc(input logic [3:0] v, input int limit);
		acp16_wrap_inc = (int'(v) >= limit - 1) ? 4'h0 : v + 4'h1;
	endfunction : acp16_wrap_inc

	// Free-running prescalers; run regardless of selection
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			div12_reg <= 4'h0;
			div4_reg <= 2'h0;
		end else begin
			div12_reg <= acp16_wrap_inc(div12_reg, ACP16_DIV12_COUNT);
			div4_reg <= 2'(acp16_wrap_inc({2'h0, div4_reg}, ACP16_DIV4_COUNT));
		end
	end

	// Edge input; three-stage filter limits usable rate to clock/4
	acp16_sync u_ext_sync (
		.clk(clk),
		.rst(rst),
		.async_in(external_count_input),
		.level_out(),
		.fall_pulse(ext_fall)
	);

	// Divided oscillator comes from another clock, so it is synchronised
	acp16_sync u_xosc_sync (
		.clk(clk),
		.rst(rst),
		.async_in(ext_osc_div8),
		.level_out(xosc_level),
		.fall_pulse()
	);

	// Rising edge of the synchronised oscillator level
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			xosc_prev_reg <= 1'b0;
		end else begin
			xosc_prev_reg <= xosc_level;
		end
	end

	assign xosc_rise = xosc_level & ~xosc_prev_reg;

	// Source mux: each source except the system clock is a single-cycle enable; the system clock enables every cycle
	always_comb begin
		unique case (timebase_select)
			ACP16_TB_DIV12: src_tick = (div12_reg == 4'h0);
			ACP16_TB_DIV4: src_tick = (div4_reg == 2'h0);
			ACP16_TB_TIMER0: src_tick = timer0_overflow;
			ACP16_TB_EXT_EDGE: src_tick = ext_fall;
			ACP16_TB_SYSTEM_CLOCK: src_tick = 1'b1;
			ACP16_TB_XOSC8: src_tick = xosc_rise;
			default: src_tick = 1'b0; // Reserved codes never count
		endcase
	end

	// Idle only gates counting when suspend is requested; clock stays on
	assign tick = src_tick & ~(idle_suspend & cpu_idle);

	// ----------------------------------------------------------------
	// Counter, snapshot and overflow
	// ----------------------------------------------------------------
	// A byte write replaces the step, so a written cycle can neither wrap nor match
	assign count_step = tick & ~count_wr_low & ~count_wr_high;
	assign wrap = count_step & (count_reg == ACP16_COUNT_MAX);

	// Count by one per enable; software byte writes take priority
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			count_reg <= ACP16_COUNT_RESET;
		end else if (count_wr_low) begin
			count_reg[7:0] <= wr_data;
		end else if (count_wr_high) begin
			count_reg[15:8] <= wr_data;
		end else if (tick) begin
			count_reg <= count_reg + 16'h0001;
		end
	end

	// Low read latches high byte; reads touch nothing else
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			snap_reg <= ACP16_SNAP_RESET;
		end else if (count_rd_low) begin
			snap_reg <= count_reg[15:8];
		end
	end

	// Read data registered one cycle after the strobe
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rd_data <= 8'h00;
		end else if (count_rd_low) begin
			rd_data <= count_reg[7:0];
		end else if (count_rd_high) begin
			rd_data <= snap_reg;
		end
	end

	// Sticky overflow flag; a new overflow beats a same-cycle clear
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			counter_overflow_flag <= 1'b0;
		end else if (wrap) begin
			counter_overflow_flag <= 1'b1;
		end else if (overflow_flag_clear) begin
			counter_overflow_flag <= 1'b0;
		end
	end

	assign overflow_irq = counter_overflow_flag & overflow_irq_enable;

	// ----------------------------------------------------------------
	// Capture/compare module in 16-bit PWM mode
	// ----------------------------------------------------------------
	// Compare bytes; low-first order keeps the comparator off mid-update
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			compare_reg <= ACP16_COMPARE_RESET;
		end else begin
			if (compare_wr_low) begin
				compare_reg[7:0] <= wr_data;
			end
			if (compare_wr_high) begin
				compare_reg[15:8] <= wr_data;
			end
		end
	end

	// Compare byte writes steer the enable; high write wins if both
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cmp_en_reg <= 1'b0;
		end else if (compare_wr_high) begin
			cmp_en_reg <= 1'b1;
		end else if (compare_wr_low) begin
			cmp_en_reg <= 1'b0;
		end else if (comparator_enable_wr) begin
			cmp_en_reg <= comparator_enable_val;
		end
	end

	assign pwm_active = cmp_en_reg & pwm_enable & pwm_wide_select;

	acp16_pwm u_pwm (
		.clk(clk),
		.rst(rst),
		.active(pwm_active),
		.tick(count_step),
		.count(count_reg),
		.compare(compare_reg),
		.pwm_out(module_output_pin),
		.match_pulse(match_pulse)
	);

	// Sticky match flag; set beats clear
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			module_match_flag <= 1'b0;
		end else if (match_pulse && match_flag_enable) begin
			module_match_flag <= 1'b1;
		end else if (match_flag_clear) begin
			module_match_flag <= 1'b0;
		end
	end

	// Match interrupt lets software reload compare in step with the edge
	assign module_irq = module_match_flag & module_irq_enable;

	assign comparator_enable = cmp_en_reg;
	assign compare_value = compare_reg;
	assign count_value = count_reg;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_count_step: assert property (@(posedge clk) disable iff (rst)
		(tick && !count_wr_low && !count_wr_high) |=> count_reg == $past(count_reg) + 16'h0001)
		else $error("counter did not advance by one");
	a_count_hold: assert property (@(posedge clk) disable iff (rst)
		(!tick && !count_wr_low && !count_wr_high) |=> $stable(count_reg))
		else $error("counter moved without enable");
	a_snap_read: assert property (@(posedge clk) disable iff (rst)
		(count_rd_low ##1 (count_rd_high && !count_rd_low)) |=> rd_data == $past(count_reg[15:8], 2))
		else $error("high read not from snapshot");
	a_ovf_set: assert property (@(posedge clk) disable iff (rst)
		wrap |=> counter_overflow_flag)
		else $error("overflow flag not set on wrap");
	a_ovf_irq: assert property (@(posedge clk) disable iff (rst)
		overflow_irq == (counter_overflow_flag && overflow_irq_enable))
		else $error("overflow irq mismatch");
	a_idle_halt: assert property (@(posedge clk) disable iff (rst)
		(cpu_idle && idle_suspend && !count_wr_low && !count_wr_high) |=> $stable(count_reg))
		else $error("counter ran in suspended idle");
	a_system_clock_run: assert property (@(posedge clk) disable iff (rst)
		(timebase_select == ACP16_TB_SYSTEM_CLOCK && !(idle_suspend && cpu_idle)) |-> tick)
		else $error("system_clock source did not count");
	a_cmp_low_off: assert property (@(posedge clk) disable iff (rst)
		(compare_wr_low && !compare_wr_high) |=> !cmp_en_reg ##1 !module_output_pin)
		else $error("low write did not disable comparator");
	a_cmp_high_on: assert property (@(posedge clk) disable iff (rst)
		compare_wr_high |=> cmp_en_reg)
		else $error("high write did not enable comparator");
	a_pwm_rise: assert property (@(posedge clk) disable iff (rst)
		(pwm_active && count_step && count_reg + 16'h0001 == compare_reg) |=> module_output_pin)
		else $error("output not high after match");
	a_pwm_fall: assert property (@(posedge clk) disable iff (rst)
		(pwm_active && wrap && compare_reg != ACP16_COMPARE_RESET) |=> !module_output_pin)
		else $error("output not low after overflow");
	a_pwm_off: assert property (@(posedge clk) disable iff (rst)
		!pwm_active |=> !module_output_pin)
		else $error("output high while disabled");
	a_match_flag: assert property (@(posedge clk) disable iff (rst)
		(match_pulse && match_flag_enable) |=> module_match_flag)
		else $error("match flag not set");
	// Byte access, sticky flags, reserved select, output hold and single-cycle source enables
	a_ovf_sticky: assert property (@(posedge clk) disable iff (rst)
		(counter_overflow_flag && !overflow_flag_clear) |=> counter_overflow_flag)
		else $error("overflow flag dropped without clear");
	a_match_sticky: assert property (@(posedge clk) disable iff (rst)
		(module_match_flag && !match_flag_clear) |=> module_match_flag)
		else $error("match flag dropped without clear");
	a_match_gate: assert property (@(posedge clk) disable iff (rst)
		(!module_match_flag && !(match_pulse && match_flag_enable)) |=> !module_match_flag)
		else $error("match flag set without enabled match");
	a_reserved_hold: assert property (@(posedge clk) disable iff (rst)
		(timebase_select[2:1] == 2'h3) |-> !tick)
		else $error("reserved select produced a count");
	a_pwm_hold: assert property (@(posedge clk) disable iff (rst)
		(pwm_active && !match_pulse && !wrap) |=> $stable(module_output_pin))
		else $error("output moved without match or wrap");
	a_wr_low_byte: assert property (@(posedge clk) disable iff (rst)
		count_wr_low |=> count_reg[7:0] == $past(wr_data))
		else $error("count low byte write lost");
	a_wr_high_byte: assert property (@(posedge clk) disable iff (rst)
		(count_wr_high && !count_wr_low) |=> count_reg[15:8] == $past(wr_data))
		else $error("count high byte write lost");
	a_rd_low_data: assert property (@(posedge clk) disable iff (rst)
		count_rd_low |=> rd_data == $past(count_reg[7:0]))
		else $error("low read returned wrong byte");
	a_cmp_low_byte: assert property (@(posedge clk) disable iff (rst)
		compare_wr_low |=> compare_reg[7:0] == $past(wr_data))
		else $error("compare low byte write lost");
	a_cmp_high_byte: assert property (@(posedge clk) disable iff (rst)
		compare_wr_high |=> compare_reg[15:8] == $past(wr_data))
		else $error("compare high byte write lost");
	a_xosc_pulse: assert property (@(posedge clk) disable iff (rst)
		xosc_rise |=> !xosc_rise)
		else $error("oscillator enable longer than one cycle");
	a_ext_pulse: assert property (@(posedge clk) disable iff (rst)
		ext_fall |=> !ext_fall)
		else $error("edge enable longer than one cycle");

	// Cover points for the main scenarios
	c_wrap: cover property (@(posedge clk) disable iff (rst) wrap);
	c_idle_halt: cover property (@(posedge clk) disable iff (rst) cpu_idle && idle_suspend);
	c_match: cover property (@(posedge clk) disable iff (rst) match_pulse);
	c_ext_count: cover property (@(posedge clk) disable iff (rst)
		timebase_select == ACP16_TB_EXT_EDGE && tick);
	c_snap: cover property (@(posedge clk) disable iff (rst) count_rd_low ##1 count_rd_high);

endmodule : acp16_top

// >>> testbench/acp16_far_end.sv
// Far-side model: count input pins and PWM load monitor
`timescale 1ns/1ps
module acp16_far_end (
	input wire logic clk, // System clock
	input wire logic pwm_pin, // Observed PWM output
	output logic edge_pin, // Count edge pin, idles high
	output logic osc_div8 // External oscillator over eight
);
	int high_cycles = 0;

	// ----------------------------------------------------------------
	// Pin drivers
	// ----------------------------------------------------------------
	// Idle levels at time zero
	initial begin
		edge_pin = 1'b1;
		osc_div8 = 1'b0;
	end

	// Each level held about four clocks, phase unrelated to clk
	task automatic edge_burst(input int n);
		repeat (n) begin
			#170 edge_pin = 1'b0;
			#150 edge_pin = 1'b1;
		end
	endtask : edge_burst

	// Foreign oscillator edges, must be synchronised inside
	task automatic osc_burst(input int n);
		repeat (n) begin
			#150 osc_div8 = 1'b1;
			#170 osc_div8 = 1'b0;
		end
	endtask : osc_burst

	// ----------------------------------------------------------------
	// Load monitor
	// ----------------------------------------------------------------
	// High time in clocks, sampled like a load would see it
	always @(posedge clk) begin
		if (pwm_pin === 1'b1) high_cycles <= high_cycles + 1;
	end
endmodule : acp16_far_end

// >>> testbench/acp16_top_bench.sv
// Self-checking bench for the counter array PWM block
`timescale 1ns/1ps
module acp16_top_bench;
	import acp16_pkg::*;
	logic clk = 1'b0, rst = 1'b1, cpu_idle = 1'b0, timer0_overflow = 1'b0;
	logic external_count_input, ext_osc_div8;
	logic [2:0] timebase_select = 3'h6;
	logic idle_suspend = 1'b0, overflow_irq_enable = 1'b0, overflow_flag_clear = 1'b0;
	logic count_wr_low = 1'b0, count_wr_high = 1'b0, count_rd_low = 1'b0, count_rd_high = 1'b0;
	logic [7:0] wr_data = 8'h00;
	logic pwm_enable = 1'b0, pwm_wide_select = 1'b0, match_flag_enable = 1'b0, module_irq_enable = 1'b0;
	logic comparator_enable_wr = 1'b0, comparator_enable_val = 1'b0;
	logic compare_wr_low = 1'b0, compare_wr_high = 1'b0, match_flag_clear = 1'b0;
	logic [7:0] rd_data;
	logic counter_overflow_flag, module_match_flag, comparator_enable, overflow_irq, module_irq;
	logic module_output_pin;
	logic [15:0] compare_value, count_value, c0, pair;
	int n_mismatch = 0, checked = 0, cycles = 0, h0;
	logic [15:0] cmp_tab [2] = '{16'hFFF0, 16'hFFFF};
	int high_tab [2] = '{16, 1};

	acp16_top i_acp16_top (.clk, .rst, .cpu_idle, .timer0_overflow, .external_count_input, .ext_osc_div8,
		.timebase_select, .idle_suspend, .overflow_irq_enable, .overflow_flag_clear, .count_wr_low,
		.count_wr_high, .count_rd_low, .count_rd_high, .wr_data, .pwm_enable, .pwm_wide_select,
		.match_flag_enable, .module_irq_enable, .comparator_enable_wr, .comparator_enable_val,
		.compare_wr_low, .compare_wr_high, .match_flag_clear, .rd_data, .counter_overflow_flag,
		.module_match_flag, .comparator_enable, .compare_value, .count_value, .overflow_irq,
		.module_irq, .module_output_pin);
	acp16_far_end i_acp16_far_end (.clk(clk), .pwm_pin(module_output_pin),
		.edge_pin(external_count_input), .osc_div8(ext_osc_div8));

	// ----------------------------------------------------------------
	// Clock, timeout and shared tasks
	// ----------------------------------------------------------------
	// 25 MHz clock
	always #20 clk = ~clk;

	// Run needs a few thousand cycles; a hang is cut at 20000
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			stop_test();
		end
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// One-cycle strobe launched on the falling edge
	task automatic strobe(ref logic s, input logic [7:0] d);
		s = 1'b1;
		wr_data = d;
		@(negedge clk) s = 1'b0;
		@(negedge clk);
	endtask : strobe

	// Coherent 16-bit read: low strobe, then high strobe on the very next clock
	task automatic read_pair(output logic [15:0] v);
		count_rd_low = 1'b1;
		@(negedge clk) count_rd_low = 1'b0;
		count_rd_high = 1'b1;
		v[7:0] = rd_data;
		@(negedge clk) count_rd_high = 1'b0;
		v[15:8] = rd_data;
		@(negedge clk);
	endtask : read_pair

	task automatic wait_zero();
		for (int i = 0; i < 1000 && count_value !== 16'h0000; i++) @(negedge clk);
	endtask : wait_zero

	task automatic stop_test();
		$display("mismatches %0d comparisons %0d", n_mismatch, checked);
		if (n_mismatch == 0 && checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : stop_test

	// ----------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (12) @(posedge clk);
		@(negedge clk) rst = 1'b0;
		@(negedge clk);
		check({count_value[14:0], module_output_pin}, 16'h0000);
		check({counter_overflow_flag, module_match_flag, comparator_enable, compare_value[12:0]}, 16'h0000);
		check(compare_value, 16'h0000);
		// Reserved select freezes the count while bytes are written and read
		strobe(count_wr_high, 8'hFF);
		strobe(count_wr_low, 8'hFD);
		check(count_value, 16'hFFFD);
		strobe(count_rd_low, 8'h00);
		check(rd_data, 8'hFD);
		strobe(count_wr_high, 8'h12);
		strobe(count_rd_high, 8'h00);
		check(rd_data, 8'hFF);
		check(count_value, 16'h12FD);
		// Back-to-back pair on a running count: high byte comes from the snapshot
		strobe(count_wr_low, 8'hFF);
		timebase_select = ACP16_TB_SYSTEM_CLOCK;
		read_pair(pair);
		check(pair, 16'h12FF);
		check(count_value, 16'h1302);
		timebase_select = 3'h7;
		strobe(count_wr_high, 8'hFF);
		strobe(count_wr_low, 8'hFD);
		check(count_value, 16'hFFFD);
		// Rollover sets the sticky flag; request follows the enable
		timebase_select = ACP16_TB_SYSTEM_CLOCK;
		repeat (3) @(negedge clk);
		check(count_value, 16'h0000);
		check({counter_overflow_flag, overflow_irq}, 16'h0002);
		overflow_irq_enable = 1'b1;
		repeat (5) @(negedge clk);
		check({counter_overflow_flag, overflow_irq}, 16'h0003);
		strobe(overflow_flag_clear, 8'h00);
		check(counter_overflow_flag, 1'b0);
		// Idle with and without suspend
		cpu_idle = 1'b1;
		idle_suspend = 1'b1;
		@(negedge clk) c0 = count_value;
		repeat (10) @(negedge clk);
		check(count_value - c0, 16'd0);
		idle_suspend = 1'b0;
		@(negedge clk) c0 = count_value;
		repeat (10) @(negedge clk);
		check(count_value - c0, 16'd10);
		cpu_idle = 1'b0;
		// Divided timebases, one phase step of slack
		for (int k = 0; k < 2; k++) begin
			timebase_select = k[0] ? ACP16_TB_DIV4 : ACP16_TB_DIV12;
			@(negedge clk) c0 = count_value;
			repeat (48) @(negedge clk);
			h0 = k[0] ? 12 : 4;
			check(16'((count_value - c0) >= 16'(h0 - 1) && (count_value - c0) <= 16'(h0 + 1)), 16'h0001);
		end
		timebase_select = ACP16_TB_TIMER0;
		@(negedge clk) c0 = count_value;
		repeat (5) strobe(timer0_overflow, 8'h00);
		check(count_value - c0, 16'd5);
		timebase_select = ACP16_TB_EXT_EDGE;
		@(negedge clk) c0 = count_value;
		i_acp16_far_end.edge_burst(6);
		repeat (8) @(negedge clk);
		check(count_value - c0, 16'd6);
		timebase_select = ACP16_TB_XOSC8;
		@(negedge clk) c0 = count_value;
		i_acp16_far_end.osc_burst(6);
		repeat (8) @(negedge clk);
		check(count_value - c0, 16'd6);
		// Wide PWM: low byte first, high time measured over one wrap
		timebase_select = ACP16_TB_SYSTEM_CLOCK;
		pwm_enable = 1'b1;
		pwm_wide_select = 1'b1;
		module_irq_enable = 1'b1;
		for (int k = 0; k < 2; k++) begin
			match_flag_enable = ~k[0];
			strobe(compare_wr_low, cmp_tab[k][7:0]);
			check(comparator_enable, 1'b0);
			strobe(compare_wr_high, cmp_tab[k][15:8]);
			check({comparator_enable, compare_value[14:0]}, {1'b1, cmp_tab[k][14:0]});
			check(compare_value[15], cmp_tab[k][15]);
			strobe(match_flag_clear, 8'h00);
			strobe(count_wr_high, 8'hFF);
			wait_zero();
			h0 = i_acp16_far_end.high_cycles;
			strobe(count_wr_high, 8'hFF);
			wait_zero();
			check(16'(i_acp16_far_end.high_cycles - h0), 16'(high_tab[k]));
			check({module_match_flag, module_irq}, {14'h0, ~k[0], ~k[0]});
		end
		// Compare of zero gives a steady high output
		strobe(compare_wr_low, 8'h00);
		strobe(compare_wr_high, 8'h00);
		strobe(count_wr_high, 8'hFF);
		wait_zero();
		repeat (40) @(negedge clk);
		check(module_output_pin, 1'b1);
		strobe(compare_wr_low, 8'h00);
		@(negedge clk);
		check(module_output_pin, 1'b0);
		// Without the wide select the output stays low
		pwm_wide_select = 1'b0;
		comparator_enable_val = 1'b1;
		strobe(comparator_enable_wr, 8'h00);
		h0 = i_acp16_far_end.high_cycles;
		strobe(count_wr_high, 8'hFF);
		wait_zero();
		repeat (20) @(negedge clk);
		check(16'(i_acp16_far_end.high_cycles - h0), 16'd0);
		// Comparator switched off directly keeps the output low at compare zero
		pwm_wide_select = 1'b1;
		comparator_enable_val = 1'b0;
		strobe(comparator_enable_wr, 8'h00);
		check(comparator_enable, 1'b0);
		h0 = i_acp16_far_end.high_cycles;
		strobe(count_wr_high, 8'hFF);
		wait_zero();
		repeat (20) @(negedge clk);
		check(16'(i_acp16_far_end.high_cycles - h0), 16'd0);
		stop_test();
	end
endmodule : acp16_top_bench
